// ===== design/ce_port_pkg.sv
// constants and types for the bidirectional analog-assisted port
package ce_port_pkg;
    localparam int          PORT_WIDTH     = 4;
    localparam int          ADDR_WIDTH     = 4;
    localparam logic [3:0]  DIR_OFFSET     = 4'h1;
    localparam logic [3:0]  DATA_OFFSET    = 4'h4;
    localparam logic [3:0]  DIR_RESET      = 4'h0;
    localparam logic [3:0]  DATA_RESET     = 4'h0;
    localparam logic [3:0]  READ_RESET     = 4'h0;
    localparam int          CMP1_BIT       = 0;
    localparam int          PIN1_BIT       = 1;
    localparam int          CMP2_BIT       = 2;
    localparam int          PIN3_BIT       = 3;

    typedef enum logic [1:0] {
        MODE_PLAIN    = 2'b00,
        MODE_OPAMP    = 2'b01,
        MODE_TWO_CMP  = 2'b10,
        MODE_CMP_OP   = 2'b11
    } port_mode_t;
endpackage

// ===== design/ce_port_comparator_readback.sv
// bidirectional 4-bit port with comparator and read-zero readback
`timescale 1ns/10ps
module ce_port_comparator_readback #(
    parameter int WIDTH = 4
) (
    input  wire logic                              mclk_in,
    input  wire logic                              rst_in,
    input  wire logic [ce_port_pkg::ADDR_WIDTH-1:0] addr_in,
    input  wire logic [WIDTH-1:0]                  wdata_in,
    input  wire logic                              wr_in,
    input  wire logic                              rd_in,
    output logic      [WIDTH-1:0]                  rdata_out,
    input  wire logic                              opamp_enable_in,
    input  wire logic                              first_comparator_enable_in,
    input  wire logic                              second_comparator_enable_in,
    input  wire logic                              bit1_read_zero_option_in,
    input  wire logic                              bit3_read_zero_option_in,
    input  wire logic [WIDTH-1:0]                  pulldown_option_in,
    input  wire logic [WIDTH-1:0]                  pin_in,
    input  wire logic                              first_comparator_in,
    input  wire logic                              second_comparator_in,
    output logic      [WIDTH-1:0]                  pin_out,
    output logic      [WIDTH-1:0]                  pin_oe_out,
    output logic      [WIDTH-1:0]                  pulldown_out
);
    import ce_port_pkg::*;

    // pins and comparator outputs are asynchronous: two-stage synchronisers
    typedef struct packed {
        logic [WIDTH-1:0] dir;
        logic [WIDTH-1:0] data;
        logic [WIDTH-1:0] rdata;
        logic [WIDTH-1:0] pin_s1;
        logic [WIDTH-1:0] pin_s2;
        logic [1:0]       cmp_s1;
        logic [1:0]       cmp_s2;
    } state_t;

    state_t     state_reg;
    state_t     state_next;
    port_mode_t mode;
    logic [WIDTH-1:0] port_view;
    logic [WIDTH-1:0] read_view;

    // options are straps wired at build time, never touched by software
    always_comb begin
        if (opamp_enable_in && first_comparator_enable_in && !second_comparator_enable_in) begin
            mode = MODE_CMP_OP;
        end else if (first_comparator_enable_in || second_comparator_enable_in) begin
            mode = MODE_TWO_CMP;
        end else if (opamp_enable_in) begin
            mode = MODE_OPAMP;
        end else begin
            mode = MODE_PLAIN;
        end
    end

    // outputs read back the latch, inputs the synchronised pin
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            assign port_view[gi]    = state_reg.dir[gi] ? state_reg.data[gi]
                                                        : state_reg.pin_s2[gi];
            assign pin_oe_out[gi]   = state_reg.dir[gi];
            assign pin_out[gi]      = state_reg.data[gi] & state_reg.dir[gi];
            assign pulldown_out[gi] = ~state_reg.dir[gi] & pulldown_option_in[gi];
        end
    endgenerate

    always_comb begin
        read_view = port_view;
        case (mode)
            MODE_PLAIN: begin
                read_view = port_view;
            end
            MODE_OPAMP: begin
                // op-amp needs no readback override; bit 1 left to software
                read_view = port_view;
            end
            MODE_TWO_CMP: begin
                if (first_comparator_enable_in) begin
                    read_view[CMP1_BIT] = state_reg.cmp_s2[0];
                    read_view[PIN1_BIT] = bit1_read_zero_option_in ? 1'b0
                                                                   : state_reg.pin_s2[PIN1_BIT];
                end
                if (second_comparator_enable_in) begin
                    read_view[CMP2_BIT] = state_reg.cmp_s2[1];
                    read_view[PIN3_BIT] = bit3_read_zero_option_in ? 1'b0
                                                                   : state_reg.pin_s2[PIN3_BIT];
                end
            end
            MODE_CMP_OP: begin
                read_view[CMP1_BIT] = state_reg.cmp_s2[0];
                read_view[PIN1_BIT] = bit1_read_zero_option_in ? 1'b0
                                                               : state_reg.pin_s2[PIN1_BIT];
                read_view[CMP2_BIT] = 1'b0;
                read_view[PIN3_BIT] = 1'b0;
            end
            default: begin
                read_view = port_view;
            end
        endcase
    end

    always_comb begin
        state_next        = state_reg;
        state_next.pin_s1 = pin_in;
        state_next.pin_s2 = state_reg.pin_s1;
        state_next.cmp_s1 = {second_comparator_in, first_comparator_in};
        state_next.cmp_s2 = state_reg.cmp_s1;
        state_next.rdata  = READ_RESET;
        if (wr_in && addr_in == DIR_OFFSET) begin
            state_next.dir = wdata_in;
        end
        if (wr_in && addr_in == DATA_OFFSET) begin
            state_next.data = wdata_in;
        end
        // unmapped addresses read zero; only the two registers are writable
        if (rd_in && addr_in == DIR_OFFSET) begin
            state_next.rdata = state_reg.dir;
        end else if (rd_in && addr_in == DATA_OFFSET) begin
            state_next.rdata = read_view;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg.dir    <= DIR_RESET;
            state_reg.data   <= DATA_RESET;
            state_reg.rdata  <= READ_RESET;
            state_reg.pin_s1 <= '0;
            state_reg.pin_s2 <= '0;
            state_reg.cmp_s1 <= '0;
            state_reg.cmp_s2 <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata_out = state_reg.rdata;
endmodule

// ===== verif/ce_port_assertions.sv
// assertion checker for the ce port
`timescale 1ns/10ps
module ce_port_checker #(parameter int WIDTH = 4) (
    input logic             mclk_in, rst_in, wr_in, rd_in, opamp_enable_in,
    input logic             first_comparator_enable_in, second_comparator_enable_in,
    input logic             bit1_read_zero_option_in, bit3_read_zero_option_in,
    input logic             first_comparator_in,
    input logic [3:0]       addr_in,
    input logic [WIDTH-1:0] wdata_in, rdata_out, pulldown_option_in,
    input logic [WIDTH-1:0] pin_out, pin_oe_out, pulldown_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    wire rdd = rd_in && addr_in == 4'h4;
    wire c1 = first_comparator_enable_in;
    property p_dir; wr_in && addr_in == 4'h1 |=> pin_oe_out == $past(wdata_in); endproperty
    a_dir: assert property (p_dir) else $error("direction not applied");
    property p_drv; wr_in && addr_in == 4'h4 |=> pin_out == ($past(wdata_in) & pin_oe_out);
    endproperty
    a_drv: assert property (p_drv) else $error("pin drive wrong");
    property p_pd; pulldown_out == (pulldown_option_in & ~pin_oe_out); endproperty
    a_pd: assert property (p_pd) else $error("pull-down wrong");
    // comparator reaches the read data through two sync stages and the read register
    property p_c1; rdd && c1 |=> rdata_out[0] == $past(first_comparator_in, 3); endproperty
    a_c1: assert property (p_c1) else $error("comparator bit wrong");
    property p_b1z; rdd && c1 && bit1_read_zero_option_in |=> !rdata_out[1]; endproperty
    a_b1z: assert property (p_b1z) else $error("bit 1 not zero");
    property p_b3z; rdd && second_comparator_enable_in && bit3_read_zero_option_in
        |=> !rdata_out[3]; endproperty
    a_b3z: assert property (p_b3z) else $error("bit 3 not zero");
    property p_m3; rdd && opamp_enable_in && c1 && !second_comparator_enable_in
        |=> rdata_out[3:2] == 2'b00; endproperty
    a_m3: assert property (p_m3) else $error("upper bits not zero");
    property p_pl; rdd && !opamp_enable_in && !c1 && !second_comparator_enable_in
        && pin_oe_out == 4'hF |=> rdata_out == $past(pin_out); endproperty
    a_pl: assert property (p_pl) else $error("plain read wrong");
endmodule

// ===== verif/ce_port_far_side.sv
// external pin model for the ce port
`timescale 1ns/10ps
module ce_port_far_side (
    input  logic [3:0] drive_in, oe_in, pull_in, ext_in,
    output logic [3:0] level_out
);
    // a pulled released pin has no external source here, so it sits low
    assign level_out = (oe_in & drive_in) | (~oe_in & ~pull_in & ext_in);
endmodule

// ===== verif/tb.sv
// self-checking bench for the ce port
`timescale 1ns/10ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin err_total++; \
    $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb;
    logic       mclk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, c1 = 1, c2 = 1;
    logic [3:0] addr_in = 0, wdata_in = 0, pd = 0, ext = 0, pin_in, rdata_out, pin_out, oe, pdo;
    logic [4:0] cfg = 0;
    int         err_total = 0, tests_run = 0;
    logic [8:0] modes [10] = '{9'h00A, 9'h03A, 9'h08B, 9'h0A9, 9'h04E, 9'h056, 9'h0ED,
                               9'h183, 9'h1B1, 9'h10A};
    always #50 mclk_in = ~mclk_in;
    ce_port_comparator_readback ce_port_comparator_readback_inst (.mclk_in, .rst_in, .addr_in,
        .wdata_in, .wr_in, .rd_in, .rdata_out, .opamp_enable_in(cfg[4]),
        .first_comparator_enable_in(cfg[3]), .second_comparator_enable_in(cfg[2]),
        .bit1_read_zero_option_in(cfg[1]), .bit3_read_zero_option_in(cfg[0]),
        .pulldown_option_in(pd), .pin_in, .first_comparator_in(c1),
        .second_comparator_in(c2), .pin_out, .pin_oe_out(oe), .pulldown_out(pdo));
    ce_port_far_side ce_port_far_side_inst (.drive_in(pin_out), .oe_in(oe), .pull_in(pdo),
        .ext_in(ext), .level_out(pin_in));
    task automatic do_reset(input logic [4:0] c);
        @(posedge mclk_in) rst_in <= 1;
        cfg <= c;
        repeat (10) @(posedge mclk_in);
        rst_in <= 0;
        repeat (3) @(posedge mclk_in);
    endtask
    task automatic wr(input logic [3:0] a, d);
        @(posedge mclk_in) wr_in <= 1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge mclk_in) wr_in <= 0;
    endtask
    task automatic rdc(input logic [3:0] a, e, input string n);
        @(posedge mclk_in) rd_in <= 1;
        addr_in <= a;
        @(posedge mclk_in) rd_in <= 0;
        #1 `CHK(n, e, rdata_out)
    endtask
    task automatic print_verdict;
        if (err_total == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #200000 err_total++;
        print_verdict;
    end
    initial begin
        do_reset(5'h00);
        rdc(4'h1, 4'h0, "dir reset");
        rdc(4'h4, 4'h0, "data reset");
        wr(4'h1, 4'hF);
        wr(4'h4, 4'h5);
        rdc(4'h4, 4'h5, "latch");
        `CHK("pins", 4'h5, pin_out)
        pd <= 4'hA;
        ext <= 4'h4;
        wr(4'h1, 4'h3);
        wr(4'h4, 4'hB);
        wr(4'h7, 4'hF);
        rdc(4'h4, 4'h7, "mixed");
        `CHK("pull", 4'h8, pdo)
        rdc(4'h7, 4'h0, "unmapped");
        rdc(4'h1, 4'h3, "dir");
        pd <= 4'h0;
        ext <= 4'hA;
        foreach (modes[i]) begin
            do_reset(modes[i][8:4]);
            rdc(4'h4, modes[i][3:0], "mode read");
        end
        print_verdict;
    end
endmodule
bind ce_port_comparator_readback ce_port_checker #(.WIDTH(WIDTH)) ce_port_checker_inst (.*);
